// ---- bench/rqm_host_model.sv ----
`timescale 1ns/100ps
module rqm_host_model
	import rqm_pkg::*;
(
	input  wire logic        clk_in,
	input  wire logic        ce_in,
	input  wire logic        ready_in,
	output logic [15:0]      word_out,
	output logic             valid_out,
	output logic             thread_out
);
	initial begin
		word_out = 16'h0000;
		valid_out = 1'b0;
		thread_out = 1'b0;
	end
	task automatic send(input logic t, input logic [15:0] s,
		input logic [31:0] k, input logic [15:0] op, input logic [7:0] o, r);
		logic [15:0] w [6];
		w = '{RQM_CMD_CALC_DATA, s, k[31:16], k[15:0], op, {o, r}};
		@(posedge clk_in);
		thread_out <= t;
		for (int i = 0; i < 6; i++) begin
			word_out <= w[i];
			valid_out <= 1'b1;
			do @(negedge clk_in); while (!(ready_in && ce_in));
			@(posedge clk_in);
		end
		valid_out <= 1'b0;
		// Idle bus shows garbage, not the last word
		word_out <= ~w[5];
	endtask
endmodule

// ---- bench/rqm_register_queue_math_unit_properties.sv ----
`timescale 1ns/100ps
module rqm_checker (
	input  wire logic       clk_in,
	input  wire logic       rst_b_in,
	input  wire logic       ce_in,
	input  wire logic       word_ready_out,
	input  wire logic       ack_out,
	input  wire logic       cmd_err_out,
	input  wire logic [1:0] zero_out,
	input  wire logic [1:0] pos_out,
	input  wire logic [1:0] neg_out
);
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_b_in);

	property p_excl;
		!(ack_out && cmd_err_out);
	endproperty
	a_excl: assert property (p_excl) else $error("ack with error");
	property p_onehot;
		$onehot0({zero_out[0], pos_out[0], neg_out[0]}) &&
		$onehot0({zero_out[1], pos_out[1], neg_out[1]});
	endproperty
	a_onehot: assert property (p_onehot) else $error("flags clash");
	property p_ack_pulse;
		(ack_out || cmd_err_out) && ce_in |=> !ack_out && !cmd_err_out;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack");
	property p_answer;
		$fell(word_ready_out) |-> ##[2:300] (ack_out || cmd_err_out);
	endproperty
	a_answer: assert property (p_answer) else $error("no answer");
	property p_presave;
		$fell(word_ready_out) |=> !ack_out && !cmd_err_out;
	endproperty
	a_presave: assert property (p_presave) else $error("early");
	property p_ready_ans;
		(ack_out || cmd_err_out) |-> word_ready_out;
	endproperty
	a_ready_ans: assert property (p_ready_ans) else $error("busy");
	property p_flags_hold;
		!ack_out |-> $stable({zero_out, pos_out, neg_out});
	endproperty
	a_flags_hold: assert property (p_flags_hold) else $error("flags");
	property p_err_flags;
		cmd_err_out |-> $stable({zero_out, pos_out, neg_out});
	endproperty
	a_err_flags: assert property (p_err_flags) else $error("err");
endmodule

bind rqm_register_queue_math_unit rqm_checker u_chk (.clk_in, .rst_b_in, .ce_in,
	.word_ready_out, .ack_out, .cmd_err_out, .zero_out, .pos_out, .neg_out);

// ---- bench/rqm_register_queue_math_unit_test.sv ----
`timescale 1ns/100ps
module rqm_register_queue_math_unit_test;
	import rqm_pkg::*;
	logic        clk_in = 1'b0, rst_b_in = 1'b0, ce_in = 1'b1, jit = 1'b0;
	logic        reg_wr_in = 1'b0, valid, thr, rdy, ack, err;
	logic [7:0]  reg_addr_in = 8'h00;
	logic [31:0] reg_wdata_in = 32'h0, reg_rdata_out;
	logic [15:0] word;
	logic [1:0]  z, p, n;
	logic [2:0]  fl [2];
	logic [31:0] q [$];
	int          seed = 51, errors = 0, cmp_count = 0;

	always #2 clk_in = ~clk_in;
	// Stalls only inside commands so side reads stay exact
	always @(posedge clk_in) ce_in <= jit ? ($random(seed) % 4 != 0) : 1'b1;

	rqm_host_model host (.clk_in(clk_in), .ce_in(ce_in), .ready_in(rdy),
		.word_out(word), .valid_out(valid), .thread_out(thr));
	rqm_register_queue_math_unit DUT (.clk_in(clk_in), .rst_b_in(rst_b_in),
		.ce_in(ce_in), .word_in(word), .word_valid_in(valid),
		.word_thread_in(thr), .word_ready_out(rdy), .ack_out(ack),
		.cmd_err_out(err), .zero_out(z), .pos_out(p), .neg_out(n),
		.reg_wr_in(reg_wr_in), .reg_addr_in(reg_addr_in),
		.reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out));

	function automatic logic [2:0] flg(input logic [31:0] v);
		return v == 0 ? 3'b100 : v[31] ? 3'b001 : 3'b010;
	endfunction
	function automatic logic [31:0] isqrt(input logic [63:0] x);
		logic [63:0] r, c;
		r = 0;
		for (int i = 31; i >= 0; i--) begin
			c = r | (64'h1 << i);
			if (c * c <= x) r = c;
		end
		return r[31:0];
	endfunction
	task chk(input logic [31:0] g, e);
		cmp_count++;
		if (g !== e) begin
			errors++;
			$display("BAD %0t got %h exp %h", $time, g, e);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk_in);
		reg_wr_in <= 1'b1;
		reg_addr_in <= a;
		reg_wdata_in <= v;
		@(posedge clk_in);
		reg_wr_in <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk_in);
		reg_addr_in <= a;
		@(posedge clk_in);
		@(negedge clk_in);
		chk(reg_rdata_out, e);
	endtask
	task cmd(input logic t, input logic [7:0] s, input logic [31:0] k,
		input logic [15:0] op, input logic [7:0] o, r, input logic ee);
		int i;
		@(negedge clk_in);
		jit = 1'b1;
		host.send(t, {8'h00, s}, k, op, o, r);
		for (i = 0; i < 400 && !(ack || err); i++)
			@(negedge clk_in);
		jit = 1'b0;
		if (i == 400) errors++;
		chk({31'h0, err}, {31'h0, ee});
	endtask
	task fchk;
		for (int j = 0; j < 2; j++)
			chk({29'h0, z[j], p[j], n[j]}, {29'h0, fl[j]});
	endtask
	task summarize;
		if (errors == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial begin
		#80000;
		errors++;
		summarize();
	end

	initial begin
		logic [31:0] a, b, v, e50;
		logic [63:0] w, pr;
		logic [7:0]  opn;
		logic        t, ok, st;
		int          ix, kd;
		e50 = 0;
		repeat (5) @(posedge clk_in);
		rst_b_in <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			a = i ? $random(seed) : 32'hffffffff;
			b = i ? $random(seed) : 32'hffffffff;
			wr(8'h1e, a);
			cmd(0, 8'h1e, b, RQM_OP_MUL64, 8'h00, 8'h28, 0);
			pr = {32'h0, a} * {32'h0, b};
			rd(8'h28, pr[31:0]);
			rd(8'h29, pr[63:32]);
			w = i ? {$random(seed), $random(seed)} : 64'hffffffffffffffff;
			wr(8'h1e, w[31:0]);
			wr(8'h1f, w[63:32]);
			b = i ? (b | 32'h1) : 32'h1;
			cmd(1, 8'h1e, b, RQM_OP_DIV64, 8'h00, 8'h2a, 0);
			pr = w / {32'h0, b};
			rd(8'h2a, pr[31:0]);
			cmd(0, 8'h1e, 0, RQM_OP_SQRT64, 8'h00, 8'h2b, 0);
			rd(8'h2b, isqrt(w));
		end
		cmd(0, 8'h1e, 0, RQM_OP_DIV64, 8'h00, 8'h2a, 1);
		cmd(0, 8'h1e, 0, 16'h0063, 8'h00, 8'h2a, 1);
		rd(8'h2a, pr[31:0]);
		wr(8'h2c, a);
		cmd(0, 8'h1e, b, RQM_OP_MUL64, RQM_OPT_PRESAVE, 8'h2c, 0);
		rd(RQM_ACC_REG, a);
		wr(8'h2c, ~a);
		cmd(1, 8'h1e, b, RQM_OP_MUL64, RQM_OPT_PRESAVE, 8'h2c, 0);
		rd(RQM_ACC_REG, a);
		// Thread two reading the accumulator sees its private copy
		cmd(1, RQM_ACC_REG, 32'h1, RQM_OP_MUL64, 8'h00, 8'h2e, 0);
		rd(8'h2e, ~a);
		cmd(0, 8'h14, 32'h3, RQM_OP_QINIT, 8'h00, 8'h00, 0);
		cmd(1, 8'h14, 32'h3, RQM_OP_QINIT, 8'h00, 8'h00, 0);
		rd(8'h14, 32'h3);
		fl[0] = 3'b100;
		fl[1] = 3'b100;
		fchk();
		for (int i = 0; i < 60; i++) begin
			opn = 8'd26 + 8'($unsigned($random(seed)) % 10);
			t = $random(seed);
			v = $random(seed);
			ix = $unsigned($random(seed)) % 4;
			st = opn < 8'd31;
			kd = (opn - 26) % 5;
			ok = kd == 4 ? ix < q.size() : kd[0] ? q.size() > 0 : q.size() < 3;
			if (ok) begin
				case (kd)
					0: q.push_front(v);
					1: e50 = q.pop_front();
					2: q.push_back(v);
					3: e50 = q.pop_back();
					default: e50 = q[ix];
				endcase
				if (!kd[0] && kd != 4) e50 = q.size();
			end
			if (kd == 4) v = ix;
			cmd(t, 8'h14, v, {8'h00, opn}, 8'h00, 8'h32, st && !ok);
			if (ok) fl[t] = st ? flg(e50) : 3'b100;
			else if (!st) fl[t] = 3'b001;
			rd(8'h32, e50);
			fchk();
		end
		summarize();
	end
endmodule

// ---- src/rqm_pkg.sv ----
package rqm_pkg;

	localparam logic [15:0] RQM_CMD_CALC_DATA = 16'h00c8;
	localparam logic [2:0]  RQM_FRAME_LAST    = 3'h5;

	localparam logic [15:0] RQM_OP_QINIT  = 16'h0019;
	localparam logic [15:0] RQM_OP_SPUSHH = 16'h001a;
	localparam logic [15:0] RQM_OP_SPOPH  = 16'h001b;
	localparam logic [15:0] RQM_OP_SPUSHT = 16'h001c;
	localparam logic [15:0] RQM_OP_SPOPT  = 16'h001d;
	localparam logic [15:0] RQM_OP_SREAD  = 16'h001e;
	localparam logic [15:0] RQM_OP_FPUSHH = 16'h001f;
	localparam logic [15:0] RQM_OP_FPOPH  = 16'h0020;
	localparam logic [15:0] RQM_OP_FPUSHT = 16'h0021;
	localparam logic [15:0] RQM_OP_FPOPT  = 16'h0022;
	localparam logic [15:0] RQM_OP_FREAD  = 16'h0023;
	localparam logic [15:0] RQM_OP_MUL64  = 16'h0064;
	localparam logic [15:0] RQM_OP_DIV64  = 16'h0065;
	localparam logic [15:0] RQM_OP_SQRT64 = 16'h0066;

	localparam logic [7:0]  RQM_ACC_REG     = 8'h0a;
	localparam logic [7:0]  RQM_OPT_PRESAVE = 8'h01;

	// Queue header word held in the base register
	localparam int          RQM_SIZE_LSB = 0;
	localparam int          RQM_HEAD_LSB = 8;
	localparam int          RQM_CNT_LSB  = 16;

	localparam logic [6:0]  RQM_DIV_STEPS  = 7'h40;
	localparam logic [6:0]  RQM_SQRT_STEPS = 7'h20;
	localparam logic [31:0] RQM_REG_RESET  = 32'h0000_0000;

	typedef enum logic [2:0] {
		RQM_ST_COLLECT,
		RQM_ST_PRESAVE,
		RQM_ST_EXEC,
		RQM_ST_DIV,
		RQM_ST_SQRT
	} rqm_state_t;

endpackage

// ---- src/rqm_register_queue_math_unit.sv ----
`timescale 1ns/100ps
module rqm_register_queue_math_unit
	import rqm_pkg::*;
#(
	parameter int NUM_REGS = 256
) (
	input  wire logic        clk_in,
	input  wire logic        rst_b_in,
	input  wire logic        ce_in,
	input  wire logic [15:0] word_in,
	input  wire logic        word_valid_in,
	input  wire logic        word_thread_in,
	output logic             word_ready_out,
	output logic             ack_out,
	output logic             cmd_err_out,
	output logic [1:0]       zero_out,
	output logic [1:0]       pos_out,
	output logic [1:0]       neg_out,
	input  wire logic        reg_wr_in,
	input  wire logic [7:0]  reg_addr_in,
	input  wire logic [31:0] reg_wdata_in,
	output logic [31:0]      reg_rdata_out
);

	if (NUM_REGS < 16 || NUM_REGS > 256) begin
		$error("NUM_REGS must lie in 16..256");
	end

	rqm_state_t  state_r;
	logic [2:0]  word_cnt_r;
	logic        thr_r;
	logic [7:0]  p1_r;
	logic [31:0] dat_r;
	logic [15:0] op_r;
	logic [7:0]  opt_r;
	logic [7:0]  res_r;
	logic [31:0] regs_r [NUM_REGS];
	logic [31:0] acc2_r;
	logic [63:0] num_r;
	logic [33:0] rem_r;
	logic [31:0] root_r;
	logic [6:0]  step_r;

	// Thread two sees its private accumulator at the accumulator address
	function automatic logic [31:0] rd(input logic [7:0] a, input logic t);
		if (t && a == RQM_ACC_REG)
			return acc2_r;
		if (32'(a) >= NUM_REGS)
			return RQM_REG_RESET;
		return regs_r[a];
	endfunction

	function automatic logic [7:0] wrap(input logic [7:0] a,
		input logic [7:0] b, input logic [7:0] size);
		logic [8:0] s;
		s = {1'b0, a} + {1'b0, b};
		if (s >= {1'b0, size})
			s = s - {1'b0, size};
		return s[7:0];
	endfunction

	// Frame intake; input comes from logic on this clock
	assign word_ready_out = (state_r == RQM_ST_COLLECT);

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			word_cnt_r <= 3'h0;
			thr_r      <= 1'b0;
			p1_r       <= 8'h00;
			dat_r      <= RQM_REG_RESET;
			op_r       <= 16'h0000;
			opt_r      <= 8'h00;
			res_r      <= 8'h00;
		end else if (ce_in && word_valid_in && word_ready_out) begin
			// A first word other than the calculation code is dropped
			if (word_cnt_r != 3'h0 || word_in == RQM_CMD_CALC_DATA)
				word_cnt_r <= (word_cnt_r == RQM_FRAME_LAST) ?
					3'h0 : word_cnt_r + 3'h1;
			case (word_cnt_r)
			3'h0:
				if (word_in == RQM_CMD_CALC_DATA)
					thr_r <= word_thread_in;
			3'h1:
				p1_r <= word_in[7:0];
			3'h2:
				dat_r[31:16] <= word_in;
			3'h3:
				dat_r[15:0] <= word_in;
			3'h4:
				op_r <= word_in;
			default: begin
				res_r <= word_in[7:0];
				opt_r <= word_in[15:8];
			end
			endcase
		end
	end

	// Operation decode and queue arithmetic
	logic [31:0] hdr;
	logic [7:0]  q_size;
	logic [7:0]  q_head;
	logic [7:0]  q_cnt;
	logic [7:0]  prev_head;
	logic [7:0]  slot;
	logic [31:0] elem;
	logic [63:0] prod;
	logic        is_flag_op;
	logic        ok;
	logic        err;
	logic        go_div;
	logic        go_sqrt;
	logic        wa_en;
	logic [31:0] wa_data;
	logic        wb_en;
	logic [7:0]  wb_addr;
	logic [31:0] wb_data;
	logic        wc_en;
	logic [31:0] wc_data;
	logic [31:0] flag_val;

	always_comb begin
		hdr        = rd(p1_r, thr_r);
		q_size     = hdr[RQM_SIZE_LSB+:8];
		q_head     = hdr[RQM_HEAD_LSB+:8];
		q_cnt      = hdr[RQM_CNT_LSB+:8];
		prev_head  = (q_head == 8'h00) ? q_size - 8'h01 : q_head - 8'h01;
		prod       = {32'h0, rd(p1_r, thr_r)} * {32'h0, dat_r};
		is_flag_op = (op_r >= RQM_OP_FPUSHH && op_r <= RQM_OP_FREAD);
		ok         = 1'b1;
		err        = 1'b0;
		go_div     = 1'b0;
		go_sqrt    = 1'b0;
		slot       = q_head;
		wa_en      = 1'b0;
		wa_data    = hdr;
		wb_en      = 1'b0;
		wb_addr    = res_r;
		wb_data    = dat_r;
		wc_en      = 1'b0;
		wc_data    = RQM_REG_RESET;
		case (op_r)
		RQM_OP_SPUSHH, RQM_OP_FPUSHH, RQM_OP_SPUSHT, RQM_OP_FPUSHT:
			slot = (op_r == RQM_OP_SPUSHH || op_r == RQM_OP_FPUSHH) ?
				prev_head : wrap(q_head, q_cnt, q_size);
		RQM_OP_SPOPT, RQM_OP_FPOPT:
			slot = wrap(q_head, q_cnt - 8'h01, q_size);
		RQM_OP_SREAD, RQM_OP_FREAD:
			slot = wrap(q_head, dat_r[7:0], q_size);
		default:
			slot = q_head;
		endcase
		elem = rd(p1_r + 8'h01 + slot, thr_r);
		case (op_r)
		RQM_OP_QINIT: begin
			wa_en   = 1'b1;
			wa_data = 32'h0;
			wa_data[RQM_SIZE_LSB+:8] = dat_r[7:0];
		end
		RQM_OP_SPUSHH, RQM_OP_FPUSHH, RQM_OP_SPUSHT, RQM_OP_FPUSHT: begin
			ok      = (q_cnt < q_size);
			wa_en   = ok;
			wb_en   = ok;
			wc_en   = ok;
			wb_addr = p1_r + 8'h01 + slot;
			wc_data = {24'h0, q_cnt + 8'h01};
			wa_data[RQM_CNT_LSB+:8] = q_cnt + 8'h01;
			if (op_r == RQM_OP_SPUSHH || op_r == RQM_OP_FPUSHH)
				wa_data[RQM_HEAD_LSB+:8] = prev_head;
		end
		RQM_OP_SPOPH, RQM_OP_FPOPH, RQM_OP_SPOPT, RQM_OP_FPOPT: begin
			ok      = (q_cnt != 8'h00);
			wa_en   = ok;
			wc_en   = ok;
			wc_data = elem;
			wa_data[RQM_CNT_LSB+:8] = q_cnt - 8'h01;
			if (op_r == RQM_OP_SPOPH || op_r == RQM_OP_FPOPH)
				wa_data[RQM_HEAD_LSB+:8] = wrap(q_head, 8'h01, q_size);
		end
		RQM_OP_SREAD, RQM_OP_FREAD: begin
			ok      = (dat_r < {24'h0, q_cnt});
			wc_en   = ok;
			wc_data = elem;
		end
		RQM_OP_MUL64: begin
			wb_en   = 1'b1;
			wb_addr = res_r + 8'h01;
			wb_data = prod[63:32];
			wc_en   = 1'b1;
			wc_data = prod[31:0];
		end
		RQM_OP_DIV64: begin
			// No quotient exists for a zero divisor
			err    = (dat_r == 32'h0);
			go_div = !err;
		end
		RQM_OP_SQRT64:
			go_sqrt = 1'b1;
		default:
			err = 1'b1;
		endcase
		if (!ok && !is_flag_op)
			err = 1'b1;
		flag_val = (op_r == RQM_OP_QINIT) ? 32'h0 : wc_data;
	end

	function automatic logic [2:0] flags_of(input logic [31:0] v);
		if (v == 32'h0)
			return 3'b100;
		return v[31] ? 3'b001 : 3'b010;
	endfunction

	// Sequencer
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state_r <= RQM_ST_COLLECT;
		end else if (ce_in) begin
			case (state_r)
			RQM_ST_COLLECT:
				if (word_valid_in && word_cnt_r == RQM_FRAME_LAST)
					state_r <= RQM_ST_PRESAVE;
			RQM_ST_PRESAVE:
				state_r <= RQM_ST_EXEC;
			RQM_ST_EXEC:
				state_r <= go_div ? RQM_ST_DIV :
					(go_sqrt ? RQM_ST_SQRT : RQM_ST_COLLECT);
			RQM_ST_DIV, RQM_ST_SQRT:
				if (step_r == 7'h01)
					state_r <= RQM_ST_COLLECT;
			default:
				state_r <= RQM_ST_COLLECT;
			endcase
		end
	end

	// Shift-subtract engines: divide and square root
	logic [32:0] div_rem;
	logic [33:0] sq_rem;
	logic [33:0] sq_trial;
	assign div_rem  = {rem_r[31:0], num_r[63]};
	assign sq_rem   = {rem_r[31:0], num_r[63:62]};
	assign sq_trial = {root_r, 2'b01};

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			num_r  <= 64'h0;
			rem_r  <= 34'h0;
			root_r <= 32'h0;
			step_r <= 7'h00;
		end else if (ce_in) begin
			case (state_r)
			RQM_ST_EXEC: begin
				num_r  <= {rd(p1_r + 8'h01, thr_r), rd(p1_r, thr_r)};
				rem_r  <= 34'h0;
				root_r <= 32'h0;
				step_r <= go_div ? RQM_DIV_STEPS : RQM_SQRT_STEPS;
			end
			RQM_ST_DIV: begin
				step_r <= step_r - 7'h01;
				if (div_rem >= {1'b0, dat_r}) begin
					rem_r <= {1'b0, div_rem - {1'b0, dat_r}};
					num_r <= {num_r[62:0], 1'b1};
				end else begin
					rem_r <= {1'b0, div_rem};
					num_r <= {num_r[62:0], 1'b0};
				end
			end
			RQM_ST_SQRT: begin
				step_r <= step_r - 7'h01;
				num_r  <= {num_r[61:0], 2'b00};
				if (sq_rem >= sq_trial) begin
					rem_r  <= sq_rem - sq_trial;
					root_r <= {root_r[30:0], 1'b1};
				end else begin
					rem_r  <= sq_rem;
					root_r <= {root_r[30:0], 1'b0};
				end
			end
			default: ;
			endcase
		end
	end
	logic        iter_done;
	logic [31:0] iter_res;
	assign iter_done = (state_r == RQM_ST_DIV || state_r == RQM_ST_SQRT)
		&& step_r == 7'h01;
	// Quotients beyond 32 bits keep only the low word
	assign iter_res = (state_r == RQM_ST_DIV) ?
		{num_r[30:0], (div_rem >= {1'b0, dat_r})} :
		{root_r[30:0], (sq_rem >= sq_trial)};

	// Data registers; thread two presave and res_r writes to the accumulator go to its private copy, others there (MUL64 high word too) are dropped
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			for (int i = 0; i < NUM_REGS; i++)
				regs_r[i] <= RQM_REG_RESET;
			acc2_r <= RQM_REG_RESET;
		end else if (ce_in) begin
			if (reg_wr_in && state_r == RQM_ST_COLLECT
				&& 32'(reg_addr_in) < NUM_REGS)
				regs_r[reg_addr_in] <= reg_wdata_in;
			if (state_r == RQM_ST_PRESAVE && opt_r == RQM_OPT_PRESAVE) begin
				if (thr_r)
					acc2_r <= rd(res_r, thr_r);
				else
					regs_r[RQM_ACC_REG] <= rd(res_r, thr_r);
			end
			if (state_r == RQM_ST_EXEC && !err) begin
				if (wa_en && !(thr_r && p1_r == RQM_ACC_REG)
					&& 32'(p1_r) < NUM_REGS)
					regs_r[p1_r] <= wa_data;
				if (wb_en && !(thr_r && wb_addr == RQM_ACC_REG)
					&& 32'(wb_addr) < NUM_REGS)
					regs_r[wb_addr] <= wb_data;
				if (wc_en && !(thr_r && res_r == RQM_ACC_REG)
					&& 32'(res_r) < NUM_REGS)
					regs_r[res_r] <= wc_data;
				if (thr_r && wc_en && res_r == RQM_ACC_REG)
					acc2_r <= wc_data;
			end
			if (iter_done) begin
				if (thr_r && res_r == RQM_ACC_REG)
					acc2_r <= iter_res;
				else if (32'(res_r) < NUM_REGS)
					regs_r[res_r] <= iter_res;
			end
		end
	end

	// Per-thread flags and the answer pulses
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			zero_out    <= 2'b00;
			pos_out     <= 2'b00;
			neg_out     <= 2'b00;
			ack_out     <= 1'b0;
			cmd_err_out <= 1'b0;
		end else if (ce_in) begin
			ack_out     <= 1'b0;
			cmd_err_out <= 1'b0;
			if (state_r == RQM_ST_EXEC) begin
				cmd_err_out <= err;
				ack_out     <= !err && !go_div && !go_sqrt;
				if (is_flag_op) begin
					zero_out[thr_r] <= ok;
					pos_out[thr_r]  <= 1'b0;
					neg_out[thr_r]  <= !ok;
				end else if (!err && !go_div && !go_sqrt) begin
					{zero_out[thr_r], pos_out[thr_r], neg_out[thr_r]}
						<= flags_of(flag_val);
				end
			end
			if (iter_done) begin
				ack_out <= 1'b1;
				{zero_out[thr_r], pos_out[thr_r], neg_out[thr_r]}
					<= flags_of(iter_res);
			end
		end
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in)
			reg_rdata_out <= RQM_REG_RESET;
		else if (ce_in)
			reg_rdata_out <= rd(reg_addr_in, 1'b0);
	end
endmodule
